// ==== inc/sfa_pkg.sv ====
// Constants and types shared by the packed-SIMD / floating-point state alias block.
package sfa_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam int NREG = 8;
	localparam int IDX_W = 3;
	localparam int MANT_W = 64;
	localparam int EXP_W = 16;
	localparam int FREG_W = MANT_W + EXP_W;
	localparam int TAG_W = 2 * NREG;

	// Word indices of the registers; byte address is index times four.
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_CMD = 4'h1;
	localparam logic [3:0] REG_DATA_LO = 4'h2;
	localparam logic [3:0] REG_DATA_HI = 4'h3;
	localparam logic [3:0] REG_FSTAT = 4'h4;
	localparam logic [3:0] REG_FEATURE = 4'h5;
	localparam logic [3:0] REG_IRQ_STAT = 4'h6;
	localparam logic [3:0] REG_IRQ_MASK = 4'h7;
	localparam logic [3:0] REG_WIN_SEL = 4'h8;
	localparam logic [3:0] REG_WIN_LO = 4'h9;
	localparam logic [3:0] REG_WIN_HI = 4'ha;
	localparam logic [3:0] REG_WIN_EXP = 4'hb;
	localparam logic [3:0] REG_SNAP_STAT = 4'hc;

	// Field positions.
	localparam int CTRL_EMUL_BIT = 2;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_IDX_LSB = 4;
	localparam int CMD_LOCK_BIT = 8;
	localparam int CMD_WREG_BIT = 9;
	localparam int CMD_RAISE_BIT = 10;
	localparam int FSTAT_TOP_LSB = 16;
	localparam int FSTAT_PEND_BIT = 19;
	localparam int FSTAT_BUSY_BIT = 20;
	localparam int WIN_SNAP_BIT = 8;
	localparam int FEAT_SIMD_BIT = 23;

	// Interrupt status bits.
	localparam int IRQ_N = 5;
	localparam int IRQ_UD = 0;
	localparam int IRQ_NUMERR = 1;
	localparam int IRQ_PACKED = 2;
	localparam int IRQ_EMPTY = 3;
	localparam int IRQ_SAVED = 4;

	localparam logic [1:0] TAG_VALID = 2'h0;
	localparam logic [1:0] TAG_EMPTY = 2'h3;
	localparam logic [IDX_W-1:0] TOP_ZERO = 3'h0;
	localparam logic [EXP_W-1:0] EXP_ONES = 16'hffff;
	localparam logic [DATA_W-1:0] LEAF_FEATURES = 32'h0000_0001;
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [IRQ_N-1:0] IRQ_RESET = 5'h00;
	localparam logic [TAG_W-1:0] TAG_RESET = 16'hffff;

	typedef enum logic [2:0] {
		OP_NOP = 3'h0,
		OP_PACKED = 3'h1,
		OP_EMPTY = 3'h2,
		OP_FLOAT = 3'h3,
		OP_IDENT = 3'h4,
		OP_SAVE = 3'h5,
		OP_XSAVE = 3'h6,
		OP_BAD = 3'h7
	} sfa_op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SAVE = 2'b10
	} sfa_state_t;
endpackage

// ==== inc/sfa_state_if.sv ====
// Carrier between the controller and the tag and register-file modules.
`timescale 1ns/100ps
interface sfa_state_if;
	logic pk_commit;
	logic empty_commit;
	logic reg_wr;
	logic [sfa_pkg::IDX_W-1:0] wr_idx;
	logic [sfa_pkg::MANT_W-1:0] wr_data;
	logic snap_start;
	logic save_en;
	logic [sfa_pkg::IDX_W-1:0] save_idx;
	logic [sfa_pkg::IDX_W-1:0] win_idx;
	logic win_snap;
	logic [sfa_pkg::FREG_W-1:0] win_data;
	logic [sfa_pkg::TAG_W-1:0] tag_word;
	logic [sfa_pkg::IDX_W-1:0] stack_top;
	logic [sfa_pkg::TAG_W-1:0] snap_tag;
	logic [sfa_pkg::IDX_W-1:0] snap_top;
	modport ctl(output pk_commit, empty_commit, reg_wr, wr_idx, wr_data, snap_start,
		save_en, save_idx, win_idx, win_snap,
		input win_data, tag_word, stack_top, snap_tag, snap_top);
	modport tags(input pk_commit, empty_commit, snap_start,
		output tag_word, stack_top, snap_tag, snap_top);
	modport regs(input reg_wr, wr_idx, wr_data, save_en, save_idx, win_idx, win_snap,
		output win_data);
endinterface

// ==== logic/sfa_tag_ctl.sv ====
// Tag word and stack-top state, with the copy taken at the start of a save.
`timescale 1ns/100ps
module sfa_tag_ctl (
	input wire logic sys_clk,
	input wire logic rst,
	sfa_state_if.tags st
);
	import sfa_pkg::*;

	logic [TAG_W-1:0] tag_reg;
	logic [IDX_W-1:0] top_reg;
	logic [TAG_W-1:0] snap_tag_reg;
	logic [IDX_W-1:0] snap_top_reg;

	// Both updates land on the same edge as the register result.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tag_reg <= TAG_RESET;
		end else if (st.empty_commit) begin
			tag_reg <= {NREG{TAG_EMPTY}}; // RULE3
		end else if (st.pk_commit) begin
			tag_reg <= {NREG{TAG_VALID}}; // RULE2 RULE17
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			top_reg <= TOP_ZERO;
		end else if (st.pk_commit) begin
			top_reg <= TOP_ZERO; // RULE4 RULE17
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			snap_tag_reg <= TAG_RESET;
			snap_top_reg <= TOP_ZERO;
		end else if (st.snap_start) begin
			snap_tag_reg <= tag_reg; // RULE1
			snap_top_reg <= top_reg;
		end
	end

	assign st.tag_word = tag_reg;
	assign st.stack_top = top_reg;
	assign st.snap_tag = snap_tag_reg;
	assign st.snap_top = snap_top_reg;
endmodule

// ==== logic/sfa_reg_file.sv ====
// Physical floating-point registers, shared by the packed registers, plus the save image.
`timescale 1ns/100ps
module sfa_reg_file (
	input wire logic sys_clk,
	input wire logic rst,
	sfa_state_if.regs rf
);
	import sfa_pkg::*;

	logic [FREG_W-1:0] live_mem [NREG];
	logic [FREG_W-1:0] snap_mem [NREG];

	// Packed register n is the mantissa of physical register n, whatever the stack top.
	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					live_mem[gi] <= '0;
				end else if (rf.reg_wr && rf.wr_idx == IDX_W'(gi)) begin
					live_mem[gi] <= {EXP_ONES, rf.wr_data}; // RULE5 RULE15 RULE16 RULE17
				end
			end
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					snap_mem[gi] <= '0;
				end else if (rf.save_en && rf.save_idx == IDX_W'(gi)) begin
					snap_mem[gi] <= live_mem[gi]; // RULE10
				end
			end
		end
	endgenerate

	assign rf.win_data = rf.win_snap ? snap_mem[rf.win_idx] : live_mem[rf.win_idx];
endmodule

// ==== logic/sfa_top.sv ====
// Controller for the packed-SIMD state aliased onto the floating-point state, Avalon-MM slave.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps

// Functional notes
// (RULE1) Packed state lives in floating-point storage; saves capture both, no extra mode.
// (RULE2) Every packed instruction except empty-state sets all tag fields to valid, 00.
// (RULE3) The empty-state instruction sets all tag fields to empty, 11.
// (RULE4) Packed instructions except empty-state force the stack top to zero.
// (RULE5) A packed register write sets exponent bits 79..64 to all ones.
// (RULE6) Identification leaf 1 reports packed support in feature bit 23.
// (RULE7) Unsupported packed op, or emulation bit 2 set, gives an invalid-opcode fault.
// (RULE8) Without the identification instruction, attempting it gives an invalid-opcode fault.
// (RULE9) Floating-point instructions use the shared state as is, modifying nothing first.
// (RULE10) Both full save instructions also store the aliased packed registers.
// (RULE11) Software saves packed registers and issues empty-state before floating-point code.
// (RULE12) Software may skip empty-state when mixing with the later vector extensions.
// (RULE13) A pending floating-point exception makes the next packed op raise numeric error.
// (RULE14) A lock prefix on a packed instruction gives an invalid-opcode fault.
// (RULE15) Packed registers and tags map onto the physical registers and tags.
// (RULE16) Packed register n is bits 63..0 of physical register n, ignoring stack top.
// (RULE17) Tag, top and exponent updates commit with the register result, same edge.
module sfa_top #(
	parameter bit SIMD_SUPPORTED = 1'b1,
	parameter bit HAS_IDENT = 1'b1
) (
	sys_clk,
	rst,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_readdata,
	avs_waitrequest,
	irq,
	numeric_error_output,
	invalid_opcode_fault
);
	import sfa_pkg::*;

	input wire logic sys_clk;
	input wire logic rst;
	input wire logic [sfa_pkg::ADDR_W-1:0] avs_address;
	input wire logic avs_read;
	input wire logic avs_write;
	input wire logic [sfa_pkg::DATA_W-1:0] avs_writedata;
	input wire logic [3:0] avs_byteenable;
	output logic [sfa_pkg::DATA_W-1:0] avs_readdata;
	output logic avs_waitrequest;
	output logic irq;
	output logic numeric_error_output;
	output logic invalid_opcode_fault;

	localparam logic [DATA_W-1:0] FEAT_FLAGS = DATA_W'(SIMD_SUPPORTED) << FEAT_SIMD_BIT;

	// Writes honour byte enables; used for the control, operand data and window-select registers.
	function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v, input logic [3:0] be);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// The packed class: both the ordinary packed op and the empty-state op.
	function automatic logic is_packed(input sfa_op_t op);
		return (op == OP_PACKED) || (op == OP_EMPTY);
	endfunction

	sfa_state_if st ();

	sfa_tag_ctl u_tags (
		.sys_clk(sys_clk),
		.rst(rst),
		.st(st.tags)
	);

	sfa_reg_file u_regs (
		.sys_clk(sys_clk),
		.rst(rst),
		.rf(st.regs)
	);

	logic wait_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] ctrl_reg;
	logic [DATA_W-1:0] data_lo_reg;
	logic [DATA_W-1:0] data_hi_reg;
	logic [DATA_W-1:0] feat_reg;
	logic [IRQ_N-1:0] irq_stat_reg;
	logic [IRQ_N-1:0] irq_mask_reg;
	logic [DATA_W-1:0] win_sel_reg;
	logic fp_pend_reg;
	logic numerr_reg;
	logic ud_reg;
	logic irq_reg;
	sfa_state_t state_reg;
	sfa_state_t state_next;
	logic [IDX_W-1:0] save_idx_reg;

	logic [3:0] word_idx;
	logic busy;
	logic stall;
	logic rd_acc;
	logic wr_acc;
	logic cmd_go;
	sfa_op_t cmd_op;
	logic cmd_lock;
	logic cmd_wreg;
	logic cmd_raise;
	logic [IDX_W-1:0] cmd_idx;
	logic fault_ud;
	logic fault_ne;
	logic simd_ok;
	logic save_go;
	logic [IRQ_N-1:0] irq_set;
	logic [IRQ_N-1:0] irq_clr;
	logic [DATA_W-1:0] rd_mux;

	assign word_idx = avs_address[ADDR_W-1:2];
	assign busy = (state_reg == ST_SAVE);

	// A command that arrives during a save is held off with waitrequest, so it is never lost.
	assign stall = avs_write && word_idx == REG_CMD && busy;
	assign rd_acc = avs_read && !wait_reg;
	assign wr_acc = avs_write && !wait_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 1'b1;
		end else if ((avs_read || avs_write) && wait_reg && !stall) begin
			wait_reg <= 1'b0;
		end else begin
			wait_reg <= 1'b1;
		end
	end

	assign cmd_go = wr_acc && word_idx == REG_CMD;
	assign cmd_op = sfa_op_t'(avs_writedata[CMD_OP_LSB +: 3]);
	assign cmd_idx = avs_writedata[CMD_IDX_LSB +: IDX_W];
	assign cmd_lock = avs_writedata[CMD_LOCK_BIT];
	assign cmd_wreg = avs_writedata[CMD_WREG_BIT];
	assign cmd_raise = avs_writedata[CMD_RAISE_BIT];

	always_comb begin
		fault_ud = 1'b0;
		if (cmd_go) begin
			if (is_packed(cmd_op)) begin
				fault_ud = !SIMD_SUPPORTED || ctrl_reg[CTRL_EMUL_BIT] || cmd_lock; // RULE7 RULE14
			end else if (cmd_op == OP_IDENT) begin
				fault_ud = !HAS_IDENT; // RULE8
			end else begin
				fault_ud = (cmd_op == OP_BAD);
			end
		end
	end

	// Invalid opcode outranks the numeric error; a faulted op commits nothing.
	assign fault_ne = cmd_go && is_packed(cmd_op) && !fault_ud && fp_pend_reg; // RULE13
	assign simd_ok = cmd_go && is_packed(cmd_op) && !fault_ud && !fp_pend_reg;
	assign save_go = cmd_go && (cmd_op == OP_SAVE || cmd_op == OP_XSAVE);

	assign st.pk_commit = simd_ok && cmd_op == OP_PACKED; // RULE2 RULE4
	assign st.empty_commit = simd_ok && cmd_op == OP_EMPTY; // RULE3
	assign st.reg_wr = simd_ok && cmd_op == OP_PACKED && cmd_wreg; // RULE5 RULE17
	assign st.wr_idx = cmd_idx; // RULE16
	assign st.wr_data = {data_hi_reg, data_lo_reg};
	assign st.snap_start = save_go; // RULE1
	assign st.save_en = busy;
	assign st.save_idx = save_idx_reg;
	assign st.win_idx = win_sel_reg[IDX_W-1:0];
	assign st.win_snap = win_sel_reg[WIN_SNAP_BIT];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= ZERO_WORD;
		end else if (wr_acc && word_idx == REG_CTRL) begin
			ctrl_reg <= be_merge(ctrl_reg, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			data_lo_reg <= ZERO_WORD;
			data_hi_reg <= ZERO_WORD;
		end else if (wr_acc && word_idx == REG_DATA_LO) begin
			data_lo_reg <= be_merge(data_lo_reg, avs_writedata, avs_byteenable);
		end else if (wr_acc && word_idx == REG_DATA_HI) begin
			data_hi_reg <= be_merge(data_hi_reg, avs_writedata, avs_byteenable);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			win_sel_reg <= ZERO_WORD;
		end else if (wr_acc && word_idx == REG_WIN_SEL) begin
			win_sel_reg <= be_merge(win_sel_reg, avs_writedata, avs_byteenable);
		end
	end

	// The leaf is taken from the low operand word.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			feat_reg <= ZERO_WORD;
		end else if (cmd_go && cmd_op == OP_IDENT && HAS_IDENT) begin
			feat_reg <= (data_lo_reg == LEAF_FEATURES) ? FEAT_FLAGS : ZERO_WORD; // RULE6
		end
	end

	// A floating-point op touches no shared state; it only models raising an exception.
	// The handler clears the pending flag by writing a one to its status bit.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fp_pend_reg <= 1'b0;
		end else if (cmd_go && cmd_op == OP_FLOAT && cmd_raise) begin
			fp_pend_reg <= 1'b1; // RULE9
		end else if (wr_acc && word_idx == REG_FSTAT && avs_byteenable[2] &&
			avs_writedata[FSTAT_PEND_BIT]) begin
			fp_pend_reg <= 1'b0; // RULE13
		end
	end

	// The error output stays up until the handler clears the pending exception.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			numerr_reg <= 1'b0;
		end else if (fault_ne) begin
			numerr_reg <= 1'b1; // RULE13
		end else if (!fp_pend_reg) begin
			numerr_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ud_reg <= 1'b0;
		end else begin
			ud_reg <= fault_ud; // RULE7 RULE8 RULE14
		end
	end

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (save_go) begin
					state_next = ST_SAVE;
				end
			end
			ST_SAVE: begin
				if (save_idx_reg == IDX_W'(NREG - 1)) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// One physical register is copied per cycle, so a save takes eight cycles.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			save_idx_reg <= TOP_ZERO;
		end else if (busy) begin
			save_idx_reg <= save_idx_reg + IDX_W'(1); // RULE10
		end else begin
			save_idx_reg <= TOP_ZERO;
		end
	end

	assign irq_set[IRQ_UD] = fault_ud;
	assign irq_set[IRQ_NUMERR] = fault_ne;
	assign irq_set[IRQ_PACKED] = st.pk_commit;
	assign irq_set[IRQ_EMPTY] = st.empty_commit;
	assign irq_set[IRQ_SAVED] = busy && state_next == ST_IDLE;
	assign irq_clr = (wr_acc && word_idx == REG_IRQ_STAT && avs_byteenable[0]) ?
		avs_writedata[IRQ_N-1:0] : IRQ_RESET;

	// A set in the same cycle as its clear wins, so no event is dropped.
	genvar gi;
	generate
		for (gi = 0; gi < IRQ_N; gi++) begin : g_irq
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					irq_stat_reg[gi] <= 1'b0;
				end else if (irq_set[gi]) begin
					irq_stat_reg[gi] <= 1'b1;
				end else if (irq_clr[gi]) begin
					irq_stat_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_mask_reg <= IRQ_RESET;
		end else if (wr_acc && word_idx == REG_IRQ_MASK && avs_byteenable[0]) begin
			irq_mask_reg <= avs_writedata[IRQ_N-1:0];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	always_comb begin
		rd_mux = ZERO_WORD;
		unique case (word_idx)
			REG_CTRL: rd_mux = ctrl_reg;
			REG_CMD: rd_mux = DATA_W'(busy) << FSTAT_BUSY_BIT;
			REG_DATA_LO: rd_mux = data_lo_reg;
			REG_DATA_HI: rd_mux = data_hi_reg;
			REG_FSTAT: begin
				rd_mux[TAG_W-1:0] = st.tag_word;
				rd_mux[FSTAT_TOP_LSB +: IDX_W] = st.stack_top;
				rd_mux[FSTAT_PEND_BIT] = fp_pend_reg;
				rd_mux[FSTAT_BUSY_BIT] = busy;
			end
			REG_FEATURE: rd_mux = feat_reg;
			REG_IRQ_STAT: rd_mux[IRQ_N-1:0] = irq_stat_reg;
			REG_IRQ_MASK: rd_mux[IRQ_N-1:0] = irq_mask_reg;
			REG_WIN_SEL: rd_mux = win_sel_reg;
			REG_WIN_LO: rd_mux = st.win_data[DATA_W-1:0];
			REG_WIN_HI: rd_mux = st.win_data[MANT_W-1:DATA_W];
			REG_WIN_EXP: rd_mux[EXP_W-1:0] = st.win_data[FREG_W-1:MANT_W];
			REG_SNAP_STAT: begin
				rd_mux[TAG_W-1:0] = st.snap_tag;
				rd_mux[FSTAT_TOP_LSB +: IDX_W] = st.snap_top;
			end
			default: rd_mux = ZERO_WORD;
		endcase
	end

	// Read data is latched as waitrequest falls and held through the accepting edge.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= ZERO_WORD;
		end else if (avs_read && wait_reg) begin
			rdata_reg <= rd_mux;
		end else if (rd_acc) begin
			rdata_reg <= rdata_reg;
		end
	end

	assign avs_readdata = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign irq = irq_reg;
	assign numeric_error_output = numerr_reg;
	assign invalid_opcode_fault = ud_reg;
endmodule

// ==== verif/sfa_pipe_model.sv ====
// Pipeline-side bus master that issues register requests to the alias block.
`timescale 1ns/100ps
module sfa_pipe_model (
	input wire logic sys_clk,
	output logic [sfa_pkg::ADDR_W-1:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [sfa_pkg::DATA_W-1:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [sfa_pkg::DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest
);
	import sfa_pkg::*;
	logic late = 1'b0;
	initial begin
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
	end
	// The request is held until waitrequest is seen low; only the bench watchdog ends a hang.
	task automatic req(input logic wr_en, input logic [3:0] w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= {w, 2'h0};
		avs_writedata <= d;
		avs_write <= wr_en;
		avs_read <= !wr_en;
		avs_byteenable <= 4'hf;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge sys_clk);
			n++;
		end
		// A command held off by a save may wait out the whole copy, but no longer.
		if (n > NREG + 2) begin
			late = 1'b1;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule

// ==== verif/sfa_top_asserts.sv ====
// Concurrent checks on the ports of the alias block.
`timescale 1ns/100ps
module sfa_top_asserts #(
	parameter bit SIMD_SUPPORTED = 1'b1,
	parameter bit HAS_IDENT = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [sfa_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [sfa_pkg::DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [sfa_pkg::DATA_W-1:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic numeric_error_output,
	input wire logic invalid_opcode_fault
);
	import sfa_pkg::*;
	logic acc;
	logic cmd_acc;
	logic lk;
	logic [2:0] op;
	logic emul_reg;
	assign acc = avs_write && !avs_waitrequest;
	assign cmd_acc = acc && avs_address[5:2] == REG_CMD;
	assign lk = avs_writedata[CMD_LOCK_BIT];
	assign op = avs_writedata[2:0];
	// Shadow of the emulation control bit, so fault checks need no internal signal.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			emul_reg <= 1'b0;
		end else if (acc && avs_address[5:2] == REG_CTRL && avs_byteenable[0]) begin
			emul_reg <= avs_writedata[CTRL_EMUL_BIT];
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest
		&& !(avs_write && avs_address[5:2] == REG_CMD) |=> !avs_waitrequest)
		else $error("request not answered in the next cycle");
	a_write_bounded: assert property (avs_write && avs_waitrequest |-> ##[1:12] !avs_waitrequest)
		else $error("write not answered in time");
	a_wait_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
		else $error("answer without a request");
	a_lock_fault: assert property (cmd_acc && (op == OP_BAD || (lk && (op == OP_PACKED
		|| op == OP_EMPTY))) |=> invalid_opcode_fault) else $error("missing fault on lock");
	a_packed_fault: assert property (cmd_acc && !lk && (op == OP_PACKED || op == OP_EMPTY)
		|=> invalid_opcode_fault == (emul_reg || !SIMD_SUPPORTED)) else $error("packed fault");
	a_ident_fault: assert property (cmd_acc && op == OP_IDENT
		|=> invalid_opcode_fault == !HAS_IDENT) else $error("ident fault wrong");
	a_float_clean: assert property (cmd_acc && !lk && op == OP_FLOAT
		|=> !invalid_opcode_fault) else $error("float op faulted");
	a_fault_cause: assert property (invalid_opcode_fault |-> $past(cmd_acc))
		else $error("fault without a command");
	a_err_cause: assert property ($rose(numeric_error_output) |-> $past(cmd_acc))
		else $error("numeric error without a command");
	a_err_clear: assert property ($fell(numeric_error_output)
		|-> $past(acc && avs_address[5:2] == REG_FSTAT, 2)) else $error("numeric error dropped");
endmodule
bind sfa_top sfa_top_asserts #(.SIMD_SUPPORTED(SIMD_SUPPORTED), .HAS_IDENT(HAS_IDENT))
	u_sfa_top_asserts (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq), .numeric_error_output(numeric_error_output),
	.invalid_opcode_fault(invalid_opcode_fault));

// ==== verif/test_sfa_top.sv ====
// Self-checking bench for the alias block.
`timescale 1ns/100ps
module test_sfa_top;
	import sfa_pkg::*;
	typedef struct {logic [3:0] w; logic [31:0] d; logic [3:0] r; logic [31:0] m;
		logic [31:0] e;} sfa_row_t;
	localparam logic [31:0] FM = 32'hffff_ffff;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [DATA_W-1:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [DATA_W-1:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic numeric_error_output;
	logic invalid_opcode_fault;
	logic [31:0] rdv;
	int err_count = 0;
	int samples_checked = 0;
	logic [31:0] fc[3] = '{32'h1, 32'h101, 32'h7};
	logic [31:0] fe[3] = '{32'h4, 32'h0, 32'h0};
	sfa_row_t rows[22] = '{
		'{4'h0, 32'h0, 4'h0, 32'h4, 32'h0}, '{4'h2, 32'h1122_3344, 4'h2, FM, 32'h1122_3344},
		'{4'h3, 32'h5566_7788, 4'h3, FM, 32'h5566_7788}, '{4'h1, 32'h231, 4'h4, 32'h7_ffff, 32'h0},
		'{4'h8, 32'h3, 4'h9, FM, 32'h1122_3344}, '{4'h8, 32'h3, 4'ha, FM, 32'h5566_7788},
		'{4'h8, 32'h3, 4'hb, 32'hffff, 32'hffff}, '{4'h8, 32'h0, 4'hb, 32'hffff, 32'h0},
		'{4'h1, 32'h2, 4'h4, 32'h7_ffff, 32'hffff}, '{4'h1, 32'h3, 4'h4, 32'h7_ffff, 32'hffff},
		'{4'h2, 32'h1, 4'h2, FM, 32'h1}, '{4'h1, 32'h4, 4'h5, 32'h80_0000, 32'h80_0000},
		'{4'h2, 32'h2, 4'h2, FM, 32'h2}, '{4'h1, 32'h4, 4'h5, FM, 32'h0},
		'{4'h1, 32'h5, 4'hc, 32'h7_ffff, 32'hffff}, '{4'h8, 32'h103, 4'h9, FM, 32'h1122_3344},
		'{4'h8, 32'h103, 4'hb, 32'hffff, 32'hffff}, '{4'h2, 32'haabb_ccdd, 4'h2, FM, 32'haabb_ccdd},
		'{4'h1, 32'h251, 4'h4, 32'h7_ffff, 32'h0}, '{4'h1, 32'h6, 4'hc, 32'h7_ffff, 32'h0},
		'{4'h8, 32'h105, 4'h9, FM, 32'haabb_ccdd}, '{4'hd, 32'h1234, 4'hd, FM, 32'h0}};
	sfa_top #(.SIMD_SUPPORTED(1'b1), .HAS_IDENT(1'b1)) u_sfa_top (.sys_clk(sys_clk), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.numeric_error_output(numeric_error_output), .invalid_opcode_fault(invalid_opcode_fault));
	sfa_pipe_model u_sfa_pipe_model (.sys_clk(sys_clk), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	always #10 sys_clk = ~sys_clk;
	task chk32(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: flag %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] w, input logic [31:0] d);
		u_sfa_pipe_model.req(1'b1, w, d, rdv);
	endtask
	task rdc(input logic [3:0] w, input logic [31:0] m, input logic [31:0] e);
		u_sfa_pipe_model.req(1'b0, w, 32'h0, rdv);
		chk32(rdv & m, e);
	endtask
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_count++;
		end_sim;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// Empty-state precedes the float row, and the second packed row comes after the float row with no further empty-state.
		foreach (rows[i]) begin
			wr(rows[i].w, rows[i].d);
			rdc(rows[i].r, rows[i].m, rows[i].e);
		end
		wr(4'h1, 32'h2);
		wr(4'h6, 32'h1f);
		wr(4'h7, 32'h1);
		for (int i = 0; i < 3; i++) begin
			wr(4'h0, fe[i]);
			wr(4'h1, fc[i]);
			rdc(4'h6, 32'h1, 32'h1);
			chk1(irq, 1'b1);
			rdc(4'h4, 32'hffff, 32'hffff);
			wr(4'h6, 32'h1);
		end
		// With the last fault cleared and only faults unmasked, the line must be low.
		rdc(4'h6, 32'h1, 32'h0);
		chk1(irq, 1'b0);
		wr(4'h7, 32'h2);
		wr(4'h1, 32'h403);
		rdc(4'h4, 32'h8_0000, 32'h8_0000);
		wr(4'h1, 32'h1);
		rdc(4'h6, 32'h2, 32'h2);
		chk1(numeric_error_output, 1'b1);
		chk1(irq, 1'b1);
		rdc(4'h4, 32'hffff, 32'hffff);
		wr(4'h4, 32'h8_0000);
		rdc(4'h4, 32'h8_0000, 32'h0);
		chk1(numeric_error_output, 1'b0);
		wr(4'h1, 32'h1);
		rdc(4'h4, 32'hffff, 32'h0);
		wr(4'h1, 32'h2);
		wr(4'h1, 32'h5);
		wr(4'h1, 32'h1);
		rdc(4'hc, 32'h7_ffff, 32'hffff);
		rdc(4'h4, 32'h7_ffff, 32'h0);
		rdc(4'h6, 32'h10, 32'h10);
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk1(irq, 1'b0);
		chk1(numeric_error_output, 1'b0);
		rdc(4'h4, 32'h1f_ffff, 32'hffff);
		rdc(4'h6, 32'h1f, 32'h0);
		wr(4'h8, 32'h3);
		rdc(4'h9, FM, 32'h0);
		chk1(u_sfa_pipe_model.late, 1'b0);
		end_sim;
	end
endmodule
